// ---- core/adc_seq_pkg.sv ----
// Constants, register map and types for the integrating converter sequencer
// Operation
// - Each held integrator value is digitised by a 14-bit successive approximation.
// - Integrate selected input for a fixed interval, then hold during conversion.
// - Slow integration lasts 16.67 ms, or 1.67 ms on the 5V range.
// - Fast integration lasts 250 us, or 25 us on the 5V range.
// - Optional configuration lengthens slow integration to 20 ms, except on the 5V range.
// - A calibration pass through the same path precedes each request's measurements.
// - Single-ended calibration: reference at +4/5 full scale, then grounded input.
// - Differential calibration uses references at +4/5 and -4/5 full scale.
// - Single-ended: one input against ground, one integration per result.
// - Differential: first integration high against low, second with inputs swapped.
// - Differential result is mean of magnitudes, sign taken from the first.
// - Special differential mode does only the unswapped integration.
// - Differential channel n high side is single-ended 2n-1, low side 2n.
// - Common mode overrange reports the most negative representable value.
// - Wait 450 us settling after switching an input before integrating.
// - Differential resolves one part in 15000, single-ended one in 7500.
package adc_seq_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int SETTLE_NS = 450000;
   localparam int SLOW_NS = 16670000;
   localparam int SLOW5_NS = 1670000;
   localparam int SLOW50_NS = 20000000;
   localparam int FAST_NS = 250000;
   localparam int FAST5_NS = 25000;
   localparam int HOLD_NS = 1000;
   localparam int SETTLE_CYCLES = SETTLE_NS / CLK_PERIOD_NS;
   localparam int SLOW_CYCLES = SLOW_NS / CLK_PERIOD_NS;
   localparam int SLOW5_CYCLES = SLOW5_NS / CLK_PERIOD_NS;
   localparam int SLOW50_CYCLES = SLOW50_NS / CLK_PERIOD_NS;
   localparam int FAST_CYCLES = FAST_NS / CLK_PERIOD_NS;
   localparam int FAST5_CYCLES = FAST5_NS / CLK_PERIOD_NS;
   localparam int HOLD_CYCLES = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int SAR_BITS = 14;
   localparam logic [13:0] SAR_MID = 14'h2000;
   localparam logic [15:0] OVR_CODE = 16'hE000;

   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] RESULT_ADDR = 8'h08;
   localparam logic [7:0] CAL_A_ADDR = 8'h0C;
   localparam logic [7:0] CAL_B_ADDR = 8'h10;
   localparam logic [7:0] INT_STAT_ADDR = 8'h14;
   localparam logic [7:0] INT_MASK_ADDR = 8'h18;

   localparam int CH_LSB = 0;
   localparam int DIFF_BIT = 5;
   localparam int FAST_BIT = 6;
   localparam int RNG5_BIT = 7;
   localparam int ONE_INT_BIT = 8;
   localparam int MAINS50_BIT = 9;
   localparam int START_BIT = 31;
   localparam int EV_DONE = 0;
   localparam int EV_OVR = 1;

   localparam logic [9:0] CTRL_RESET = 10'h000;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PATH_INPUT,
      PATH_REF_POS,
      PATH_REF_NEG,
      PATH_GND
   } path_e;

   typedef enum {
      S_IDLE,
      S_SETTLE,
      S_INTEG,
      S_HOLD,
      S_CONV,
      S_FINISH
   } seq_e;
endpackage : adc_seq_pkg

// ---- core/adc_seq.sv ----
// Measurement sequencer with AXI4-Lite registers and front end control
`timescale 1ns/100ps
module adc_seq #(
   parameter int SETTLE_CYCLES = adc_seq_pkg::SETTLE_CYCLES,
   parameter int SLOW_CYCLES = adc_seq_pkg::SLOW_CYCLES,
   parameter int SLOW5_CYCLES = adc_seq_pkg::SLOW5_CYCLES,
   parameter int SLOW50_CYCLES = adc_seq_pkg::SLOW50_CYCLES,
   parameter int FAST_CYCLES = adc_seq_pkg::FAST_CYCLES
) (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   output logic [3:0] MUX_CHAN,
   output logic MUX_SIDE,
   output logic MUX_DIFF,
   output logic [1:0] PATH_SEL,
   output logic SWAP,
   output logic RANGE_5V,
   output logic INTEGRATE,
   output logic HOLD,
   output logic [13:0] SAR_CODE,
   input wire logic SAR_CMP,
   input wire logic CM_OVER,
   output logic BUSY,
   output logic DONE,
   output logic IRQ
);

   typedef struct packed {
      adc_seq_pkg::seq_e state;
      logic [1:0] step;
      logic [19:0] cnt;
      logic [3:0] bit_idx;
      logic [13:0] dac;
      logic [9:0] ctrl;
      logic [9:0] cfg;
      logic [13:0] cal_a;
      logic [13:0] cal_b;
      logic [13:0] res_a;
      logic [13:0] res_b;
      logic [15:0] result;
      logic ovr;
      logic busy;
      logic done;
      logic [3:0] mux_chan;
      logic mux_side;
      adc_seq_pkg::path_e path;
      logic swap;
      logic integ;
      logic hold;
      logic [1:0] stat;
      logic [1:0] mask;
      logic irq;
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_s;

   state_s r;
   state_s next_r;
   logic [19:0] ilen;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [19:0] integ_len(input logic [9:0] c);
      logic [19:0] v;
      v = 20'(SLOW_CYCLES);
      if (c[adc_seq_pkg::FAST_BIT] && c[adc_seq_pkg::RNG5_BIT]) begin
         v = 20'(adc_seq_pkg::FAST5_CYCLES);
      end else if (c[adc_seq_pkg::FAST_BIT]) begin
         v = 20'(FAST_CYCLES);
      end else if (c[adc_seq_pkg::RNG5_BIT]) begin
         v = 20'(SLOW5_CYCLES);
      end else if (c[adc_seq_pkg::MAINS50_BIT]) begin
         v = 20'(SLOW50_CYCLES);
      end
      return v;
   endfunction : integ_len

   // Calibration steps first, then the measurement steps
   function automatic adc_seq_pkg::path_e step_path(input logic [1:0] s,
                                                    input logic diff);
      adc_seq_pkg::path_e p;
      p = adc_seq_pkg::PATH_INPUT;
      if (s == 2'd0) begin
         p = adc_seq_pkg::PATH_REF_POS;
      end else if (s == 2'd1) begin
         p = diff ? adc_seq_pkg::PATH_REF_NEG : adc_seq_pkg::PATH_GND;
      end
      return p;
   endfunction : step_path

   function automatic logic [1:0] last_step(input logic [9:0] c);
      logic [1:0] v;
      v = 2'd2;
      if (c[adc_seq_pkg::DIFF_BIT] && !c[adc_seq_pkg::ONE_INT_BIT]) begin
         v = 2'd3;
      end
      return v;
   endfunction : last_step

   // Offset binary code to signed
   function automatic logic signed [15:0] to_signed(input logic [13:0] c);
      return 16'(signed'({~c[13], c[12:0]}));
   endfunction : to_signed

   function automatic logic [15:0] magnitude(input logic signed [15:0] v);
      return v[15] ? 16'(-v) : 16'(v);
   endfunction : magnitude

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] v;
      v = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            v[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return v;
   endfunction : merge

   assign ilen = integ_len(r.cfg);

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [31:0] rd;
      logic rd_ok;
      logic start;
      logic [13:0] code;
      logic [15:0] sum;
      logic [15:0] avg;
      logic [1:0] events;
      rd = 32'h0000_0000;
      rd_ok = 1'b1;
      start = 1'b0;
      code = r.dac;
      sum = 16'h0000;
      avg = 16'h0000;
      events = 2'h0;
      next_r = r;
      next_r.done = 1'b0;

      // Write channel: address and data may arrive in either order
      if (AWVALID && r.awready) begin
         next_r.aw_full = 1'b1;
         next_r.aw_addr = AWADDR;
      end
      if (WVALID && r.wready) begin
         next_r.w_full = 1'b1;
         next_r.wdata = WDATA;
         next_r.wstrb = WSTRB;
      end
      if (BVALID && BREADY) begin
         next_r.bvalid = 1'b0;
      end
      if (r.aw_full && r.w_full && !r.bvalid) begin
         next_r.aw_full = 1'b0;
         next_r.w_full = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = adc_seq_pkg::RESP_OKAY;
         unique case (r.aw_addr)
            adc_seq_pkg::CTRL_ADDR: begin
               next_r.ctrl = 10'(merge(32'(r.ctrl), r.wdata, r.wstrb));
               start = r.wstrb[3] && r.wdata[adc_seq_pkg::START_BIT];
            end
            adc_seq_pkg::INT_STAT_ADDR: begin
               if (r.wstrb[0]) begin
                  next_r.stat = r.stat & ~r.wdata[1:0];
               end
            end
            adc_seq_pkg::INT_MASK_ADDR: begin
               if (r.wstrb[0]) begin
                  next_r.mask = r.wdata[1:0];
               end
            end
            adc_seq_pkg::STATUS_ADDR, adc_seq_pkg::RESULT_ADDR,
            adc_seq_pkg::CAL_A_ADDR, adc_seq_pkg::CAL_B_ADDR: begin
            end
            default: next_r.bresp = adc_seq_pkg::RESP_SLVERR;
         endcase
      end

      // Read channel
      unique case (ARADDR)
         adc_seq_pkg::CTRL_ADDR: rd = 32'(r.ctrl);
         adc_seq_pkg::STATUS_ADDR: rd = {31'h0000_0000, r.busy};
         adc_seq_pkg::RESULT_ADDR: rd = 32'(signed'(r.result));
         adc_seq_pkg::CAL_A_ADDR: rd = 32'(r.cal_a);
         adc_seq_pkg::CAL_B_ADDR: rd = 32'(r.cal_b);
         adc_seq_pkg::INT_STAT_ADDR: rd = 32'(r.stat);
         adc_seq_pkg::INT_MASK_ADDR: rd = 32'(r.mask);
         default: rd_ok = 1'b0;
      endcase
      if (RVALID && RREADY) begin
         next_r.rvalid = 1'b0;
      end
      if (ARVALID && r.arready) begin
         next_r.rvalid = 1'b1;
         next_r.rdata = rd;
         next_r.rresp = rd_ok ? adc_seq_pkg::RESP_OKAY
                              : adc_seq_pkg::RESP_SLVERR;
      end

      // Sequencer
      unique case (r.state)
         adc_seq_pkg::S_IDLE: begin
            // A start while busy is ignored
            if (start) begin
               next_r.cfg = next_r.ctrl;
               next_r.busy = 1'b1;
               next_r.ovr = 1'b0;
               next_r.step = 2'd0;
               next_r.cnt = 20'h00000;
               next_r.path = step_path(2'd0, next_r.ctrl[5]);
               next_r.swap = 1'b0;
               next_r.mux_chan = next_r.ctrl[5] ? next_r.ctrl[3:0]
                                 : 4'(5'(next_r.ctrl[4:0] + 5'h01) >> 1);
               next_r.mux_side = !next_r.ctrl[5] && !next_r.ctrl[0];
               next_r.state = adc_seq_pkg::S_SETTLE;
            end
         end
         adc_seq_pkg::S_SETTLE: begin
            next_r.cnt = r.cnt + 20'h00001;
            if (r.cnt == 20'(SETTLE_CYCLES - 1)) begin
               next_r.cnt = 20'h00000;
               next_r.integ = 1'b1;
               next_r.state = adc_seq_pkg::S_INTEG;
            end
         end
         adc_seq_pkg::S_INTEG: begin
            next_r.cnt = r.cnt + 20'h00001;
            if (r.cnt == ilen - 20'h00001) begin
               next_r.cnt = 20'h00000;
               next_r.integ = 1'b0;
               next_r.hold = 1'b1;
               next_r.state = adc_seq_pkg::S_HOLD;
            end
         end
         adc_seq_pkg::S_HOLD: begin
            next_r.cnt = r.cnt + 20'h00001;
            if (r.cnt == 20'(adc_seq_pkg::HOLD_CYCLES - 1)) begin
               next_r.dac = adc_seq_pkg::SAR_MID;
               next_r.bit_idx = 4'(adc_seq_pkg::SAR_BITS - 1);
               next_r.state = adc_seq_pkg::S_CONV;
            end
         end
         adc_seq_pkg::S_CONV: begin
            // One bit per cycle; the comparator must settle within a cycle
            if (!SAR_CMP) begin
               code[r.bit_idx] = 1'b0;
            end
            next_r.dac = code;
            if (r.bit_idx != 4'h0) begin
               next_r.bit_idx = r.bit_idx - 4'h1;
               next_r.dac[r.bit_idx - 4'h1] = 1'b1;
            end else begin
               next_r.hold = 1'b0;
               next_r.cnt = 20'h00000;
               unique case (r.step)
                  2'd0: next_r.cal_a = code;
                  2'd1: next_r.cal_b = code;
                  2'd2: next_r.res_a = code;
                  2'd3: next_r.res_b = code;
               endcase
               if (r.cfg[adc_seq_pkg::DIFF_BIT] && r.step[1] && CM_OVER) begin
                  next_r.ovr = 1'b1;
               end
               if (r.step == last_step(r.cfg)) begin
                  next_r.state = adc_seq_pkg::S_FINISH;
               end else begin
                  next_r.step = r.step + 2'd1;
                  next_r.path = step_path(r.step + 2'd1,
                                          r.cfg[adc_seq_pkg::DIFF_BIT]);
                  next_r.swap = (r.step == 2'd2);
                  next_r.state = adc_seq_pkg::S_SETTLE;
               end
            end
         end
         adc_seq_pkg::S_FINISH: begin
            sum = magnitude(to_signed(r.res_a)) + magnitude(to_signed(r.res_b));
            avg = sum >> 1;
            if (r.ovr) begin
               next_r.result = adc_seq_pkg::OVR_CODE;
            end else if (!r.cfg[adc_seq_pkg::DIFF_BIT]) begin
               // Halved so single-ended spans half the counts
               next_r.result = 16'(to_signed(r.res_a) >>> 1);
            end else if (r.cfg[adc_seq_pkg::ONE_INT_BIT]) begin
               next_r.result = to_signed(r.res_a);
            end else begin
               next_r.result = r.res_a[13] ? avg : 16'(-avg);
            end
            next_r.swap = 1'b0;
            next_r.path = adc_seq_pkg::PATH_GND;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            events[adc_seq_pkg::EV_DONE] = 1'b1;
            events[adc_seq_pkg::EV_OVR] = r.ovr;
            next_r.state = adc_seq_pkg::S_IDLE;
         end
      endcase

      // Set applied after the clear so a coincident event is kept
      next_r.stat = next_r.stat | events;
      next_r.irq = |(next_r.stat & next_r.mask);
      next_r.awready = !next_r.aw_full && !next_r.bvalid;
      next_r.wready = !next_r.w_full && !next_r.bvalid;
      next_r.arready = !next_r.rvalid;
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         r <= '0;
         r.state <= adc_seq_pkg::S_IDLE;
         r.path <= adc_seq_pkg::PATH_GND;
         r.ctrl <= adc_seq_pkg::CTRL_RESET;
         r.mask <= adc_seq_pkg::MASK_RESET;
         r.awready <= 1'b1;
         r.wready <= 1'b1;
         r.arready <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign AWREADY = r.awready;
   assign WREADY = r.wready;
   assign BVALID = r.bvalid;
   assign BRESP = r.bresp;
   assign ARREADY = r.arready;
   assign RVALID = r.rvalid;
   assign RDATA = r.rdata;
   assign RRESP = r.rresp;
   assign MUX_CHAN = r.mux_chan;
   assign MUX_SIDE = r.mux_side;
   assign MUX_DIFF = r.cfg[adc_seq_pkg::DIFF_BIT];
   assign RANGE_5V = r.cfg[adc_seq_pkg::RNG5_BIT];
   assign PATH_SEL = r.path;
   assign SWAP = r.swap;
   assign INTEGRATE = r.integ;
   assign HOLD = r.hold;
   assign SAR_CODE = r.dac;
   assign BUSY = r.busy;
   assign DONE = r.done;
   assign IRQ = r.irq;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_B);
   // Run lengths counted here; long repetitions are too slow to unroll
   logic [4:0] conv_cnt;
   logic [19:0] int_cnt;
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         conv_cnt <= 5'h00;
         int_cnt <= 20'h00000;
      end else begin
         conv_cnt <= (r.state == adc_seq_pkg::S_CONV) ? conv_cnt + 5'h01 : 5'h00;
         int_cnt <= INTEGRATE ? int_cnt + 20'h00001 : 20'h00000;
      end
   end
   sequence conv_run_q;
      r.state == adc_seq_pkg::S_CONV;
   endsequence
   sequence conv_exit_q;
      r.state != adc_seq_pkg::S_CONV;
   endsequence
   sar_length_a: assert property (
      conv_run_q ##1 conv_exit_q |-> conv_cnt == 5'(adc_seq_pkg::SAR_BITS))
      else $error("conversion not 14 cycles");
   hold_in_conv_a: assert property (
      r.state == adc_seq_pkg::S_CONV |-> HOLD && !INTEGRATE)
      else $error("hold missing during conversion");
   integ_len_a: assert property (
      $fell(INTEGRATE) |-> int_cnt == ilen)
      else $error("integration interval wrong");
   fast_len_a: assert property (
      $fell(INTEGRATE) && r.cfg[adc_seq_pkg::FAST_BIT]
      && r.cfg[adc_seq_pkg::RNG5_BIT]
      |-> int_cnt == 20'(adc_seq_pkg::FAST5_CYCLES))
      else $error("fast 5V interval wrong");

   settle_wait_a: assert property (
      $rose(INTEGRATE) |-> $past(r.cnt) == 20'(SETTLE_CYCLES - 1)
      && $past(r.state) == adc_seq_pkg::S_SETTLE)
      else $error("settling interval wrong");

   cal_first_a: assert property (
      $rose(BUSY) |-> PATH_SEL == adc_seq_pkg::PATH_REF_POS && !SWAP)
      else $error("calibration not first");

   swap_second_a: assert property (
      r.state == adc_seq_pkg::S_SETTLE && r.step == 2'd3
      |-> SWAP && PATH_SEL == adc_seq_pkg::PATH_INPUT)
      else $error("second integration not swapped");

   done_pulse_a: assert property (
      DONE |-> !BUSY ##1 !DONE)
      else $error("done not a single pulse");

   ovr_code_a: assert property (
      r.state == adc_seq_pkg::S_FINISH && r.ovr
      |=> r.result == adc_seq_pkg::OVR_CODE && DONE)
      else $error("overrange code missing");

   cfg_stable_a: assert property (
      BUSY && $past(BUSY) |-> $stable(r.cfg))
      else $error("settings changed during request");

endmodule : adc_seq

// ---- bench/front_end_model.sv ----
// Behavioural analog front end: references, held input, comparator
`timescale 1ns/100ps
module front_end_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [1:0] path_sel,
   input wire logic swap,
   input wire logic hold,
   input wire logic [13:0] sar_code,
   input wire logic signed [13:0] vin,
   input wire logic cm_bad,
   output logic sar_cmp,
   output logic cm_over
);
   logic [13:0] held;
   logic hold_d;
   logic tog;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         held <= 14'h0000;
         hold_d <= 1'h0;
         tog <= 1'h0;
      end else begin
         hold_d <= hold;
         tog <= ~tog;
         if (hold && !hold_d) begin
            case (path_sel)
               2'h1: held <= 14'h3999;
               2'h2: held <= 14'h0667;
               2'h3: held <= 14'h2000;
               // Swap offset of two codes exposes a wrong averaging
               default: held <= swap ? 14'h1FFE - vin : 14'h2000 + vin;
            endcase
         end
      end
   end
   // Comparator wanders outside hold, so no stale level helps
   assign sar_cmp = hold ? (held >= sar_code) : tog;
   assign cm_over = cm_bad & (path_sel == 2'h0);
endmodule : front_end_model

// ---- bench/integrating_adc_sequencer_tb.sv ----
// Register level testbench for the measurement sequencer
`timescale 1ns/100ps
module integrating_adc_sequencer_tb;
   localparam int ST = 20;
   localparam int SL = 40;
   localparam int FA = 35;
   logic CORE_CLK = 1'h0, RST_B = 1'h0;
   logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
   logic [31:0] WDATA = 32'h0, RDATA;
   logic [3:0] WSTRB = 4'hF, MUX_CHAN;
   logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
   logic ARVALID = 1'h0, RREADY = 1'h0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, MUX_SIDE, MUX_DIFF;
   logic SWAP, RANGE_5V, INTEGRATE, HOLD, SAR_CMP, CM_OVER, BUSY, DONE, IRQ;
   logic [1:0] BRESP, RRESP, PATH_SEL;
   logic [13:0] SAR_CODE;
   logic signed [13:0] vin = 14'h0400;
   logic cm_bad = 1'h0;
   int n_errors = 0, n_compared = 0;
   int n_busy, n_gap, n_hold, n_int;
   logic [2:0] seen[$];
   logic [4:0] mux;
   logic prev_int = 1'h0;
   logic [9:0] md[6] = '{10'h0C3, 10'h043, 10'h083, 10'h203, 10'h010, 10'h283};
   int ti[6] = '{625, 35, 30, 50, 40, 30};
   logic [4:0] mx[6] = '{5'h02, 5'h02, 5'h02, 5'h02, 5'h18, 5'h02};
   ////////////////////////////////////////////////////////////////////////
   adc_seq #(.SETTLE_CYCLES(ST), .SLOW_CYCLES(SL), .SLOW5_CYCLES(30),
      .SLOW50_CYCLES(50), .FAST_CYCLES(FA)) dut_u (
      .CORE_CLK(CORE_CLK), .RST_B(RST_B), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .MUX_CHAN(MUX_CHAN), .MUX_SIDE(MUX_SIDE),
      .MUX_DIFF(MUX_DIFF), .PATH_SEL(PATH_SEL), .SWAP(SWAP),
      .RANGE_5V(RANGE_5V), .INTEGRATE(INTEGRATE), .HOLD(HOLD),
      .SAR_CODE(SAR_CODE), .SAR_CMP(SAR_CMP), .CM_OVER(CM_OVER),
      .BUSY(BUSY), .DONE(DONE), .IRQ(IRQ));
   front_end_model fe_u (.clk(CORE_CLK), .rst_b(RST_B), .path_sel(PATH_SEL),
      .swap(SWAP), .hold(HOLD), .sar_code(SAR_CODE), .vin(vin),
      .cm_bad(cm_bad), .sar_cmp(SAR_CMP), .cm_over(CM_OVER));
   always #20 CORE_CLK = ~CORE_CLK;
   ////////////////////////////////////////////////////////////////////////
   // Phase counters sampled at each edge, before that edge's updates
   always @(posedge CORE_CLK) begin
      if (BUSY === 1'h1) n_busy++;
      if (BUSY === 1'h1 && INTEGRATE === 1'h0 && HOLD === 1'h0) n_gap++;
      if (HOLD === 1'h1) n_hold++;
      if (INTEGRATE === 1'h1) n_int++;
      if (INTEGRATE === 1'h1 && prev_int !== 1'h1) begin
         seen.push_back({SWAP, PATH_SEL});
         mux = {MUX_SIDE, MUX_CHAN};
      end
      prev_int = INTEGRATE;
   end
   task automatic cmp(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      bit aw, w;
      @(posedge CORE_CLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      BREADY <= 1'h1;
      aw = 0;
      w = 0;
      do begin
         @(posedge CORE_CLK);
         if (!aw && AWREADY === 1'h1) begin
            aw = 1;
            AWVALID <= 1'h0;
         end
         if (!w && WREADY === 1'h1) begin
            w = 1;
            WVALID <= 1'h0;
         end
      end while (!(aw && w));
      while (BVALID !== 1'h1) @(posedge CORE_CLK);
      r = BRESP;
      BREADY <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge CORE_CLK);
      ARADDR <= a;
      ARVALID <= 1'h1;
      RREADY <= 1'h1;
      do @(posedge CORE_CLK); while (ARREADY !== 1'h1);
      ARVALID <= 1'h0;
      while (RVALID !== 1'h1) @(posedge CORE_CLK);
      d = RDATA;
      r = RRESP;
      RREADY <= 1'h0;
   endtask : rd
   task automatic rc(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      cmp(nm, e, d);
      cmp("read response", 32'h0, r);
   endtask : rc
   // One measurement; expectations built from the chosen mode
   task automatic meas(input logic [9:0] cfg, input int integ,
      input logic [31:0] res, input logic [4:0] mx_e, input bit again);
      int steps;
      int k;
      logic [2:0] pe[4];
      logic [1:0] r;
      steps = (cfg[5] && !cfg[8]) ? 4 : 3;
      pe = '{3'h1, cfg[5] ? 3'h2 : 3'h3, 3'h0, 3'h4};
      n_busy = 0;
      n_gap = 0;
      n_hold = 0;
      n_int = 0;
      seen.delete();
      wr(adc_seq_pkg::CTRL_ADDR, {1'h1, 21'h0, cfg}, r);
      if (again) begin
         // Second start with another channel must not change the running request
         wr(adc_seq_pkg::CTRL_ADDR, {1'h1, 21'h0, cfg[9:5], 5'h01}, r);
         rc("busy status", adc_seq_pkg::STATUS_ADDR, 32'h1);
      end
      k = 0;
      do begin
         @(posedge CORE_CLK);
         k++;
      end while (DONE !== 1'h1 && k < 5000);
      cmp("done seen", 32'h1, DONE);
      cmp("busy at done", 32'h0, BUSY);
      @(posedge CORE_CLK);
      cmp("done width", 32'h0, DONE);
      cmp("busy cycles", steps * (ST + integ + 39) + 1, n_busy);
      cmp("settle cycles", steps * ST + 1, n_gap);
      cmp("integrate cycles", steps * integ, n_int);
      cmp("hold cycles", steps * 39, n_hold);
      cmp("step count", steps, seen.size());
      for (k = 0; k < steps && k < 4; k++) cmp("path", pe[k], seen[k]);
      cmp("mux select", mx_e, mux);
      cmp("diff select", cfg[5], MUX_DIFF);
      cmp("range select", cfg[7], RANGE_5V);
      rc("result", adc_seq_pkg::RESULT_ADDR, res);
      rc("cal a", adc_seq_pkg::CAL_A_ADDR, 32'h3999);
      rc("cal b", adc_seq_pkg::CAL_B_ADDR, cfg[5] ? 32'h0667 : 32'h2000);
   endtask : meas
   task automatic close_out();
      if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(40 * 40000);
      n_errors++;
      close_out();
   end
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (2) @(posedge CORE_CLK);
      RST_B <= 1'h1;
      rc("ctrl reset", adc_seq_pkg::CTRL_ADDR, 32'h0);
      rc("mask reset", adc_seq_pkg::INT_MASK_ADDR, 32'h0);
      rd(8'h1C, d, r);
      cmp("unmapped read", 32'h2, r);
      wr(8'h1C, 32'hFFFFFFFF, r);
      cmp("unmapped write", 32'h2, r);
      for (int i = 0; i < 6; i++) meas(md[i], ti[i], 32'h200, mx[i], 0);
      rc("done event", adc_seq_pkg::INT_STAT_ADDR, 32'h1);
      cmp("irq masked", 32'h0, IRQ);
      wr(adc_seq_pkg::INT_MASK_ADDR, 32'h3, r);
      @(posedge CORE_CLK);
      cmp("irq raised", 32'h1, IRQ);
      wr(adc_seq_pkg::INT_STAT_ADDR, 32'h1, r);
      @(posedge CORE_CLK);
      cmp("irq cleared", 32'h0, IRQ);
      rc("event cleared", adc_seq_pkg::INT_STAT_ADDR, 32'h0);
      meas(10'h028, SL, 32'h401, 5'h08, 0);
      vin <= 14'h3F9C;
      meas(10'h028, SL, 32'hFFFFFF9D, 5'h08, 0);
      meas(10'h168, FA, 32'hFFFFFF9C, 5'h08, 0);
      cm_bad <= 1'h1;
      meas(10'h068, FA, 32'hFFFFE000, 5'h08, 1);
      rc("overrange event", adc_seq_pkg::INT_STAT_ADDR, 32'h3);
      cmp("irq overrange", 32'h1, IRQ);
      close_out();
   end
endmodule : integrating_adc_sequencer_tb
